// ===== logic/dual_port_slave_pkg.sv
// Constants shared by the dual port slave glue logic.
package dual_port_slave_pkg;
  localparam int RAM_BYTES = 2048;
  localparam int RAM_AW = 11;
  localparam logic [15:0] LOCAL_RAM_BASE = 16'h8000;
  localparam logic [4:0] LOCAL_RAM_TAG = 5'h10;
  localparam logic [10:0] FLAG_LOC = 11'h000;
  localparam logic [7:0] IO_TIMER_BASE = 8'he0;
  localparam logic [7:0] IO_PP0_BASE = 8'he4;
  localparam logic [7:0] IO_PP1_BASE = 8'he6;
  localparam logic [7:0] IO_PP2_BASE = 8'he8;
  localparam logic [7:0] IO_RESET_LATCH = 8'hea;
  localparam logic [7:0] IO_PIC_BASE = 8'hec;
  localparam logic [7:0] LATCH_RESET_VAL = 8'h00;
  localparam int LATCH_PP0 = 0;
  localparam int LATCH_PP1 = 1;
  localparam int LATCH_PP2 = 2;
  localparam int LATCH_BUSIRQ = 3;
  localparam int LATCH_LED = 4;
  localparam int PIC_PP0 = 0;
  localparam int PIC_PP1 = 1;
  localparam int PIC_PP2 = 2;
  localparam int PIC_TMR0 = 3;
  localparam int PIC_TMR1 = 4;
  localparam int PIC_TMR2 = 5;
  localparam int PIC_BUS_A = 6;
  localparam int PIC_BUS_B = 7;
  typedef enum logic [1:0] {ARB_IDLE, ARB_LOCAL, ARB_REMOTE} arb_state_e;
endpackage

// ===== logic/dual_port_slave_glue.sv
// Shared RAM, flag interrupt, reset latch and interrupt routing glue.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Remote bus masters read and write the shared RAM as a plain memory slave.
// R2: A remote write to shared RAM location zero sets the flag interrupt.
// R3: A local read of RAM location zero clears the flag interrupt.
// R4: The flag interrupt goes only to the local processor, not to bus lines.
// R5: The remote window base is a static 2K-aligned configuration input.
// R6: Local processor sees the RAM at 8000-87FF regardless of window base.
// R7: A configuration bit withholds the upper 1K from remote access.
// R8: Latch bits 0..2 drive resets of the three peripheral processor sockets.
// R9: Latch bit 3 drives an interrupt request onto a system bus line.
// R10: Latch bit 4 drives the diagnostic LED.
// R11: Local I/O decodes timer E0-E3, processors E4-E9, latch EA-EB, controller.
// R12: Controller inputs take three processor requests and three timer outputs.
// R13: One configured bus interrupt line routes to one of two controller inputs.
// R14: The board both accepts and raises system bus interrupts.
// R15: As sole master with expansion boards, no other bus masters exist.
// R16: Controller request output drives the local maskable interrupt input.
// R17: The withheld RAM half occupies no system address space.
// R18: Reset clears latch and flag and beats a coinciding set; a set beats a coinciding local clear.
// R19: Local and remote RAM accesses are granted one at a time.
module dual_port_slave_glue
  import dual_port_slave_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Static configuration
  input wire logic [8:0] cfgWindowBase,
  input wire logic cfgReserveHalf,
  input wire logic [2:0] cfgBusIrqSel,
  input wire logic cfgBusIrqToB,
  input wire logic [2:0] cfgBusIrqOutSel,
  // Local processor memory and I/O port
  input wire logic [15:0] locAddr,
  input wire logic [7:0] locWdata,
  input wire logic locMemRd,
  input wire logic locMemWr,
  input wire logic locIoRd,
  input wire logic locIoWr,
  output logic [7:0] locRdata,
  output logic locReady,
  // Local I/O chip selects
  output logic timerSel,
  output logic [2:0] ppSel,
  output logic picSel,
  // System bus slave port
  input wire logic [19:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busMemRd,
  input wire logic busMemWr,
  output logic [7:0] busRdata,
  output logic busAck,
  // System bus interrupt lines
  input wire logic [7:0] systemBusIrqLines,
  output logic [7:0] busIrqOut,
  // Interrupt sources and routing
  input wire logic [2:0] ppIrq,
  input wire logic [2:0] timerOut,
  input wire logic picIrqOut,
  output logic [7:0] picIrqIn,
  output logic cpuMaskableIrqInput,
  output logic flagIrq,
  // Latch outputs
  output logic [2:0] ppReset,
  output logic diagLed
);
  logic [7:0] ram [0:RAM_BYTES-1];
  arb_state_e arbReg;
  arb_state_e arbNext;
  logic flagReg;
  logic [7:0] latchReg;
  logic [RAM_AW-1:0] offReg;
  logic [7:0] wdReg;
  logic wrReg;

  function automatic logic inWindow(input logic [19:0] a, input logic [8:0] base,
                                    input logic rsv);
    inWindow = (a[19:11] == base) && !(rsv && a[10]);
  endfunction

  // Most local I/O devices answer on an even/odd address pair.
  function automatic logic ioPairHit(input logic [7:0] a, input logic [7:0] base);
    ioPairHit = (a[7:1] == base[7:1]);
  endfunction

  wire logic locRamHit = (locAddr[15:11] == LOCAL_RAM_TAG); // [R6]
  wire logic locReq = locRamHit && (locMemRd || locMemWr);
  // Upper half withheld from the bus claims no address at all. [R5] [R7] [R17]
  wire logic busHit = inWindow(busAddr, cfgWindowBase, cfgReserveHalf);
  wire logic busReq = busHit && (busMemRd || busMemWr); // [R1]
  wire logic [7:0] ioA = locAddr[7:0];
  wire logic ioAny = locIoRd || locIoWr; // [R11]
  wire logic latchHit = ioPairHit(ioA, IO_RESET_LATCH) && locIoWr; // [R11]
  wire logic timerHit = (ioA[7:2] == IO_TIMER_BASE[7:2]) && ioAny;
  wire logic pp0Hit = ioPairHit(ioA, IO_PP0_BASE) && ioAny;
  wire logic pp1Hit = ioPairHit(ioA, IO_PP1_BASE) && ioAny;
  wire logic pp2Hit = ioPairHit(ioA, IO_PP2_BASE) && ioAny;
  wire logic picHit = ioPairHit(ioA, IO_PIC_BASE) && ioAny;
  wire logic grantLocal = (arbReg == ARB_LOCAL);
  wire logic grantRemote = (arbReg == ARB_REMOTE);
  // A requester holds its strobes through its answer cycle, so a side whose
  // answer is standing must not be taken again on that edge.
  wire logic locTake = locReq && !locReady; // [R19]
  wire logic busTake = busReq && !busAck; // [R19]
  // I/O cycles are answered one cycle after their strobe is seen.
  wire logic ioTake = ioAny && !locReady;
  wire logic locReadyNext = grantLocal || ioTake;
  wire logic flagSet = grantRemote && wrReg && (offReg == FLAG_LOC); // [R2]
  wire logic flagClr = grantLocal && !wrReg && (offReg == FLAG_LOC); // [R3]
  wire logic busIrqIn = systemBusIrqLines[cfgBusIrqSel];
  wire logic [7:0] busRoute = {cfgBusIrqToB & busIrqIn, ~cfgBusIrqToB & busIrqIn, 6'h00};
  wire logic [2:0] ppSelNext = {pp2Hit, pp1Hit, pp0Hit};
  wire logic [2:0] ppResetNext = {latchReg[LATCH_PP2], latchReg[LATCH_PP1],
                                  latchReg[LATCH_PP0]};
  wire logic [7:0] busIrqOutNext = {7'h00, latchReg[LATCH_BUSIRQ]} << cfgBusIrqOutSel;
  wire logic [7:0] picIrqInNext = {busRoute[PIC_BUS_B], busRoute[PIC_BUS_A], timerOut, ppIrq};

  // Return to idle after each access; from idle a local request is granted before a remote one.
  always_comb begin
    arbNext = arbReg;
    case (arbReg)
      ARB_IDLE: begin
        if (locTake) begin
          arbNext = ARB_LOCAL; // [R19]
        end else if (busTake) begin
          arbNext = ARB_REMOTE; // [R19]
        end
      end
      ARB_LOCAL: arbNext = ARB_IDLE;
      ARB_REMOTE: arbNext = ARB_IDLE;
      default: arbNext = ARB_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arbReg <= ARB_IDLE;
      offReg <= '0;
      wdReg <= 8'h00;
      wrReg <= 1'b0;
    end else begin
      arbReg <= arbNext;
      if (arbReg == ARB_IDLE && locTake) begin
        offReg <= locAddr[RAM_AW-1:0];
        wdReg <= locWdata;
        wrReg <= locMemWr;
      end else if (arbReg == ARB_IDLE && busTake) begin
        offReg <= busAddr[RAM_AW-1:0];
        wdReg <= busWdata;
        wrReg <= busMemWr;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if ((grantLocal || grantRemote) && wrReg) begin
      ram[offReg] <= wdReg; // [R1]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      locRdata <= 8'h00;
      busRdata <= 8'h00;
      locReady <= 1'b0;
      busAck <= 1'b0;
    end else begin
      locReady <= locReadyNext;
      busAck <= grantRemote; // [R1]
      if (grantLocal) begin
        locRdata <= ram[offReg];
      end
      if (grantRemote) begin
        busRdata <= ram[offReg];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flagReg <= 1'b0; // [R18]
      latchReg <= LATCH_RESET_VAL; // [R18]
    end else begin
      // Set is tested first so a coinciding clear cannot lose the event.
      if (flagSet) begin
        flagReg <= 1'b1; // [R18]
      end else if (flagClr) begin
        flagReg <= 1'b0;
      end
      if (latchHit) begin
        latchReg <= locWdata;
      end
    end
  end

  // Chip selects follow the decoded I/O address by one cycle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timerSel <= 1'b0;
      ppSel <= 3'h0;
      picSel <= 1'b0;
    end else begin
      timerSel <= timerHit; // [R11]
      ppSel <= ppSelNext; // [R11]
      picSel <= picHit; // [R11]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ppReset <= 3'h0;
    end else begin
      ppReset <= ppResetNext; // [R8]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      diagLed <= 1'b0;
    end else begin
      diagLed <= latchReg[LATCH_LED]; // [R10]
    end
  end

  // Only the configured line is driven; the others stay released.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busIrqOut <= 8'h00;
    end else begin
      busIrqOut <= busIrqOutNext; // [R9] [R14]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      picIrqIn <= 8'h00;
    end else begin
      picIrqIn <= picIrqInNext; // [R12] [R13] [R14]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpuMaskableIrqInput <= 1'b0;
    end else begin
      cpuMaskableIrqInput <= picIrqOut; // [R16]
    end
  end

  // The flag has a private output, never one of the shared bus lines.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flagIrq <= 1'b0;
    end else begin
      flagIrq <= flagReg; // [R4]
    end
  end
endmodule // dual_port_slave_glue

// ===== test/dual_port_slave_glue_monitor.sv
// Port-level assertions for the dual port slave glue.
`timescale 1ns/1ps
module dual_port_slave_glue_monitor
  import dual_port_slave_pkg::*;
(
  // Watched ports, grouped by kind to keep the list short.
  input wire logic mclk, rst_n, cfgReserveHalf, cfgBusIrqToB, locMemRd, locIoWr, locReady,
  input wire logic busMemWr, busAck, picIrqOut, cpuMaskableIrqInput, flagIrq, diagLed,
  input wire logic [8:0] cfgWindowBase,
  input wire logic [2:0] cfgBusIrqSel, ppIrq, timerOut, ppReset,
  input wire logic [15:0] locAddr,
  input wire logic [7:0] locWdata, systemBusIrqLines, picIrqIn,
  input wire logic [19:0] busAddr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic inWin = busAddr[19:11] == cfgWindowBase && !(cfgReserveHalf && busAddr[10]);
  wire logic routeA = !cfgBusIrqToB && systemBusIrqLines[cfgBusIrqSel];
  wire logic [5:0] srcs = {timerOut, ppIrq};
  property p_flagSet; busAck && busMemWr && busAddr[10:0] == FLAG_LOC |=> flagIrq; endproperty
  a_flagSet: assert property (p_flagSet) else $error("flag not raised");
  property p_flagClr; locReady && locMemRd && locAddr == LOCAL_RAM_BASE && !busAck |=> !flagIrq;
  endproperty
  a_flagClr: assert property (p_flagClr) else $error("flag not cleared");
  property p_latch; locReady && locIoWr && locAddr[7:1] == 7'h75 |=>
    ppReset == $past(locWdata[2:0]) && diagLed == $past(locWdata[4]); endproperty
  a_latch: assert property (p_latch) else $error("latch outputs wrong");
  property p_window; busAck |-> inWin; endproperty
  a_window: assert property (p_window) else $error("ack outside window");
  property p_ackPulse; busAck |=> !busAck; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
  property p_pic; $past(rst_n) |-> picIrqIn[5:0] == $past(srcs); endproperty
  a_pic: assert property (p_pic) else $error("controller inputs wrong");
  property p_busRoute; $past(rst_n) |-> picIrqIn[PIC_BUS_A] == $past(routeA); endproperty
  a_busRoute: assert property (p_busRoute) else $error("bus irq route wrong");
  property p_cpuIrq; $past(rst_n) |-> cpuMaskableIrqInput == $past(picIrqOut); endproperty
  a_cpuIrq: assert property (p_cpuIrq) else $error("cpu irq not following");
  c_remWr: cover property (busAck && busMemWr);
  c_latch: cover property (locReady && locIoWr);
  c_flag: cover property ($rose(flagIrq));
endmodule // dual_port_slave_glue_monitor
bind dual_port_slave_glue dual_port_slave_glue_monitor mon (.mclk, .rst_n, .cfgReserveHalf,
  .cfgBusIrqToB, .locMemRd, .locIoWr, .locReady, .busMemWr, .busAck, .picIrqOut,
  .cpuMaskableIrqInput, .flagIrq, .diagLed, .cfgWindowBase, .cfgBusIrqSel, .ppIrq, .timerOut,
  .ppReset, .locAddr, .locWdata, .systemBusIrqLines, .picIrqIn, .busAddr);

// ===== test/remote_master_model.sv
// Remote system bus master that reaches the shared RAM window.
`timescale 1ns/1ps
module remote_master_model (
  // Bus side
  input wire logic mclk,
  input wire logic busAck,
  output logic [19:0] busAddr,
  output logic [7:0] busWdata,
  output logic busMemRd,
  output logic busMemWr
);
  initial {busAddr, busWdata, busMemRd, busMemWr} = '0;
  // Sole master on the bus; released lines show the inverse so stale data never matches.
  task automatic xfer(input logic [19:0] a, input logic [7:0] d, input logic wr, output logic ok);
    int n;
    @(negedge mclk);
    busAddr = a;
    busWdata = d;
    {busMemWr, busMemRd} = {wr, !wr};
    n = 0;
    do @(posedge mclk); while (!busAck && ++n < 12);
    ok = busAck;
    @(negedge mclk);
    {busMemWr, busMemRd} = 2'b00;
    {busAddr, busWdata} = ~{a, d};
  endtask
endmodule // remote_master_model

// ===== test/tb.sv
// Self-checking bench for the dual port slave glue.
`timescale 1ns/1ps
module tb
  import dual_port_slave_pkg::*;
;
  logic mclk = 0, rst_n = 0, cfgReserveHalf = 0, cfgBusIrqToB, picIrqOut = 0, ok;
  logic locMemRd = 0, locMemWr = 0, locIoRd = 0, locIoWr = 0, locReady, timerSel, picSel;
  logic busAck, busMemRd, busMemWr, cpuMaskableIrqInput, flagIrq, diagLed;
  logic [8:0] cfgWindowBase;
  logic [2:0] cfgBusIrqSel, cfgBusIrqOutSel, ppIrq = 0, timerOut = 0, ppSel, ppReset;
  logic [15:0] locAddr = 0;
  logic [7:0] locWdata = 0, systemBusIrqLines = 0, locRdata, busRdata, busWdata, busIrqOut;
  logic [7:0] picIrqIn, d;
  logic [19:0] busAddr;
  logic [7:0] exq[$];
  logic [7:0] ioAt [5] = '{IO_TIMER_BASE, IO_PP0_BASE, IO_PP1_BASE, IO_PP2_BASE, IO_PIC_BASE};
  int errorCnt = 0, nChecks = 0;
  always #2.5 mclk = ~mclk;
  dual_port_slave_glue uut (.*);
  remote_master_model rm (.mclk, .busAck, .busAddr, .busWdata, .busMemRd, .busMemWr);
  task automatic endOfTest();
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic loc(input logic [15:0] a, input logic [7:0] dat, input logic [3:0] k);
    int n;
    @(negedge mclk);
    {locAddr, locWdata} = {a, dat};
    {locIoWr, locIoRd, locMemWr, locMemRd} = k;
    n = 0;
    do @(posedge mclk); while (!locReady && ++n < 12);
    if (!locReady) begin
      errorCnt++;
      endOfTest();
    end
    @(negedge mclk);
    {locIoWr, locIoRd, locMemWr, locMemRd} = 4'h0;
  endtask
  task automatic rem(input logic [19:0] a, input logic [7:0] dat, input logic wr, expOk);
    rm.xfer(a, dat, wr, ok);
    chk(8'(ok), 8'(expOk), "busAck");
    if (expOk && !ok) endOfTest();
  endtask
  // Read results are compared in the order the drivers queued them.
  always @(posedge mclk) begin
    if ((locReady && locMemRd) || (busAck && busMemRd))
      chk(locReady ? locRdata : busRdata, exq.pop_front(), "read data");
    if (locReady && locIoRd)
      chk(8'({picSel, ppSel, timerSel}), exq.pop_front(), "io select");
  end
  initial begin
    void'($urandom(32'h998fc153));
    {cfgWindowBase, cfgBusIrqSel, cfgBusIrqOutSel, cfgBusIrqToB} = 16'($urandom);
    repeat (10) @(negedge mclk);
    rst_n = 1;
    d = 8'($urandom);
    rem({cfgWindowBase, FLAG_LOC}, d, 1'b1, 1'b1);
    repeat (2) @(negedge mclk);
    chk({flagIrq, busIrqOut[6:0]}, 8'h80, "flagIrq");
    exq.push_back(d);
    loc(LOCAL_RAM_BASE, 8'h00, 4'h1);
    @(negedge mclk);
    chk(8'(flagIrq), 8'h00, "flagIrq");
    d = 8'($urandom);
    loc(16'h83ff, d, 4'h2);
    exq.push_back(d);
    rem({cfgWindowBase, 11'h3ff}, 8'h00, 1'b0, 1'b1);
    cfgReserveHalf = 1;
    rem({cfgWindowBase, 11'h7ff}, 8'h5a, 1'b1, 1'b0);
    rem({~cfgWindowBase, 11'h000}, 8'h5a, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      loc({8'h00, IO_RESET_LATCH | 8'(i)}, d, 4'h8);
      @(negedge mclk);
      chk(8'({diagLed, ppReset}), 8'({d[4], d[2:0]}), "latch");
      chk(busIrqOut, 8'(d[3]) << cfgBusIrqOutSel, "busIrqOut");
    end
    for (int i = 0; i < 5; i++) begin
      exq.push_back(8'h01 << i);
      loc({8'h00, ioAt[i]}, 8'h00, 4'h4);
    end
    repeat (20) begin
      {ppIrq, timerOut, picIrqOut, systemBusIrqLines, cfgBusIrqToB} = 16'($urandom);
      @(negedge mclk);
      chk({cpuMaskableIrqInput, picIrqIn[6:0]}, {picIrqOut, !cfgBusIrqToB &&
        systemBusIrqLines[cfgBusIrqSel], timerOut, ppIrq}, "irq routing");
      chk(8'(picIrqIn[7]), 8'(cfgBusIrqToB && systemBusIrqLines[cfgBusIrqSel]), "route b");
    end
    endOfTest();
  end
endmodule // tb
